// ===== hw/ext_bus_pkg.sv
// constants, field layouts and region types for the bus window decoder
package ext_bus_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int SEG_W = 8;
  localparam int NUM_WIN = 4;
  // =====================================================
  // memory map bounds
  localparam logic [23:0] EXT_LOW_END = 24'h007fff;
  localparam logic [23:0] SYS_START = 24'h008000;
  localparam logic [23:0] SYS_END = 24'h00ffff;
  localparam logic [23:0] EXT_MID_END = 24'h1fffff;
  localparam logic [23:0] IO_START = 24'h200800;
  localparam logic [23:0] IO_END = 24'h3fffff;
  localparam logic [23:0] EXT_HIGH_START = 24'h400000;
  localparam logic [23:0] EXT_HIGH_END = 24'hbeffff;
  localparam logic [23:0] FLASH_START = 24'hc00000;
  localparam logic [23:0] FLASH_END = 24'hc3ffff;
  localparam logic [23:0] PROGRAM_SRAM_START = 24'he00000;
  localparam logic [23:0] PROGRAM_SRAM_END = 24'he017ff;
  localparam logic [23:0] TRAP_START = 24'hf80000;
  localparam logic [23:0] FREG_START = 24'hfff000;
  // read value of undefined flash register locations (arbitrary)
  localparam logic [15:0] FREG_TRAP_CODE = 16'h00ff;
  // =====================================================
  // window_function_config fields
  localparam int FC_W = 4;
  localparam int FC_EN = 0;
  localparam int FC_MUX = 1;
  localparam int FC_BYTE = 2;
  localparam int FC_EXP = 3;
  // window_timing_config fields
  localparam int TC_W = 5;
  localparam int TC_WAIT_LSB = 0;
  localparam int TC_WAIT_W = 4;
  localparam int TC_RECOV = 4;
  // window_range_select fields: base = A[23:12], size code = mask width
  localparam int RS_W = 16;
  localparam int RS_BASE_LSB = 4;
  localparam int RS_SIZE_W = 4;
  localparam int RS_BASE_W = 12;
  // =====================================================
  // reset values
  localparam logic [3:0] CS_N_RST = 4'hf;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [3:0] CNT_RST = 4'h0;
  typedef enum logic [2:0] {
    REG_EXTERNAL, REG_EXT_IO, REG_SYSTEM, REG_PROGRAM_SRAM, REG_FLASH, REG_FLASH_REGS, REG_TRAP
  } region_t;
endpackage

// ===== hw/external_bus_window_decoder.sv
// external bus controller: address decode, windows and bus cycle sequencer
//
// Overview of operation
// - one linear 16 MB space, 256 segments of 64 KB, four 16 KB pages each
// - every location reachable by byte or word accesses
// - internal data memories and register areas decoded in segment 0
// - external memory regions become external bus cycles
// - external I/O region accesses run strictly ordered, flagged to the pipeline
// - flash register reads return trap code; reserved area below raises trap
// - program SRAM at E0'0000..E0'17FF served internally, no external cycle
// - program flash at C0'0000..C3'FFFF decoded as internal region
// - single-chip mode plus mux/demux, 8/16-bit data, 16..23 address bits
// - demux: address on address port, data on full port or low byte
// - mux: one port carries address then data each cycle
// - segment lines on segment port, count programmable 64 KB..8 MB
// - up to four active-low chip selects: three windows plus default
// - timing and function settings per window and for default region
// - four independent address windows with own bus characteristics
// - overlap: window 4 beats 3, window 2 beats 1
// - unmatched external access uses default region settings
// - selected window asserts its select unless set for expansion; window 4 has no pin
// - bus signals change with rising edge of driven reference clock, except address phase start on any rising clk edge
// - internal expansion bus cycles look exactly like external ones
// - bus mode switches access by access per selected window
`timescale 1ns/1ps
module external_bus_window_decoder
  import ext_bus_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_enable,
  input wire logic [2:0] seg_lines,
  input wire logic [ext_bus_pkg::NUM_WIN-1:0][ext_bus_pkg::RS_W-1:0] window_range_select,
  input wire logic [ext_bus_pkg::NUM_WIN-1:0][ext_bus_pkg::FC_W-1:0] window_function_config,
  input wire logic [ext_bus_pkg::NUM_WIN-1:0][ext_bus_pkg::TC_W-1:0] window_timing_config,
  input wire logic [ext_bus_pkg::FC_W-1:0] default_function_config,
  input wire logic [ext_bus_pkg::TC_W-1:0] default_timing_config,
  input wire logic req_valid,
  input wire logic [ext_bus_pkg::ADDR_W-1:0] req_addr,
  input wire logic req_write,
  input wire logic req_word,
  input wire logic [ext_bus_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic resp_done,
  output logic [ext_bus_pkg::DATA_W-1:0] resp_rdata,
  output logic resp_trap,
  output ext_bus_pkg::region_t resp_region,
  output logic resp_ordered,
  output logic bus_reference_clock_out,
  output logic [ext_bus_pkg::DATA_W-1:0] demux_address_port,
  output logic [ext_bus_pkg::SEG_W-1:0] seg_address_port,
  output logic [ext_bus_pkg::DATA_W-1:0] shared_addr_data_port_o,
  output logic shared_addr_data_port_oe,
  input wire logic [ext_bus_pkg::DATA_W-1:0] shared_addr_data_port_i,
  output logic addr_latch,
  output logic rd_n,
  output logic wr_n,
  output logic bhe_n,
  output logic [3:0] cs_n,
  output logic exp_sel
);
  import ext_bus_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_STROBE, S_RECOV} state_t;

  // ===================================================
  // decode functions
  function automatic region_t decode(input logic [ADDR_W-1:0] a);
    region_t r;
    r = REG_TRAP;
    if (a <= EXT_LOW_END) r = REG_EXTERNAL;
    else if (a >= SYS_START && a <= SYS_END) r = REG_SYSTEM;
    else if (a <= EXT_MID_END) r = REG_EXTERNAL;
    else if (a >= IO_START && a <= IO_END) r = REG_EXT_IO;
    else if (a >= EXT_HIGH_START && a <= EXT_HIGH_END) r = REG_EXTERNAL;
    else if (a >= FLASH_START && a <= FLASH_END) r = REG_FLASH;
    else if (a >= PROGRAM_SRAM_START && a <= PROGRAM_SRAM_END) r = REG_PROGRAM_SRAM;
    else if (a >= FREG_START) r = REG_FLASH_REGS;
    else if (a >= TRAP_START) r = REG_TRAP;
    return r;
  endfunction

  function automatic logic [2:0] pick_window(input logic [ADDR_W-1:0] a);
    logic [2:0] w;
    logic [RS_BASE_W-1:0] m;
    logic [RS_SIZE_W-1:0] sz;
    w = 3'd0;
    for (int i = 0; i < NUM_WIN; i++)
    begin
      sz = window_range_select[i][RS_SIZE_W-1:0];
      m = (sz >= RS_SIZE_W'(RS_BASE_W)) ? '0 : ~((RS_BASE_W'(1) << sz) - RS_BASE_W'(1));
      // later windows override earlier ones
      if (window_function_config[i][FC_EN] &&
          (((a[ADDR_W-1:12] ^ window_range_select[i][RS_W-1:RS_BASE_LSB]) & m) == '0))
        w = 3'(i + 1);
    end
    return w;
  endfunction

  // ===================================================
  // request decode
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic wr_q;
  logic word_q;
  logic mux_q;
  logic byte_q;
  logic recov_q;
  logic exp_q;
  logic second_q;
  logic [2:0] win_q;
  logic [3:0] cnt_q;
  logic [TC_WAIT_W-1:0] wait_q;
  state_t st_q;
  region_t reg_d;
  logic [2:0] win_d;
  logic [FC_W-1:0] fc_d;
  logic [TC_W-1:0] tc_d;
  logic accept;
  logic go_ext;

  always_comb
  begin
    reg_d = decode(req_addr);
    win_d = pick_window(req_addr);
    fc_d = (win_d == 3'd0) ? default_function_config : window_function_config[win_d-3'd1];
    tc_d = (win_d == 3'd0) ? default_timing_config : window_timing_config[win_d-3'd1];
  end

  assign accept = req_valid && req_ready;
  // single-chip mode: external regions trap instead of running a cycle
  assign go_ext = bus_enable && (reg_d == REG_EXTERNAL || reg_d == REG_EXT_IO);

  // ===================================================
  // reference clock: bus steps after the address phase start coincide with its rising edge
  logic tick;
  assign tick = !bus_reference_clock_out;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) bus_reference_clock_out <= 1'b0;
    else bus_reference_clock_out <= !bus_reference_clock_out;
  end

  // ===================================================
  // read data synchroniser
  logic [DATA_W-1:0] s1_q;
  logic [DATA_W-1:0] s2_q;
  logic [DATA_W-1:0] s3_q;
  logic stable;
  assign stable = (s2_q == s3_q);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= DATA_RST;
      s2_q <= DATA_RST;
      s3_q <= DATA_RST;
    end
    else
    begin
      s1_q <= shared_addr_data_port_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ===================================================
  // lane helpers
  logic [DATA_W-1:0] wlane;
  logic [ADDR_W-1:0] next_addr;
  logic finish;
  assign next_addr = addr_q + ADDR_W'(1);
  assign finish = tick && ((st_q == S_RECOV) ||
    (st_q == S_STROBE && cnt_q == CNT_RST && (wr_q || stable) && !recov_q &&
     !(byte_q && word_q && !second_q)));

  always_comb
  begin
    if (byte_q) wlane = {8'h00, second_q ? wdata_q[15:8] : wdata_q[7:0]};
    else if (word_q) wlane = wdata_q;
    else wlane = {wdata_q[7:0], wdata_q[7:0]};
  end

  // ===================================================
  // bus cycle sequencer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= S_IDLE;
      addr_q <= ADDR_RST;
      wdata_q <= DATA_RST;
      wr_q <= 1'b0;
      word_q <= 1'b0;
      mux_q <= 1'b0;
      byte_q <= 1'b0;
      recov_q <= 1'b0;
      exp_q <= 1'b0;
      second_q <= 1'b0;
      win_q <= 3'd0;
      cnt_q <= CNT_RST;
      wait_q <= CNT_RST;
    end
    else
    begin
      unique case (st_q)
        S_IDLE:
          if (accept && go_ext)
          begin
            st_q <= S_ADDR;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            wr_q <= req_write;
            word_q <= req_word;
            mux_q <= fc_d[FC_MUX];
            byte_q <= fc_d[FC_BYTE];
            exp_q <= fc_d[FC_EXP];
            recov_q <= tc_d[TC_RECOV];
            cnt_q <= tc_d[TC_WAIT_LSB +: TC_WAIT_W];
            wait_q <= tc_d[TC_WAIT_LSB +: TC_WAIT_W];
            win_q <= win_d;
            second_q <= 1'b0;
          end
        S_ADDR:
          if (tick) st_q <= S_STROBE;
        S_STROBE:
          if (tick)
          begin
            if (cnt_q != CNT_RST) cnt_q <= cnt_q - 4'd1;
            else if (wr_q || stable)
            begin
              if (byte_q && word_q && !second_q)
              begin
                // low byte first, then high byte at the next address
                second_q <= 1'b1;
                addr_q <= next_addr;
                cnt_q <= wait_q;
                st_q <= S_ADDR;
              end
              else if (recov_q) st_q <= S_RECOV;
              else st_q <= S_IDLE;
            end
          end
        S_RECOV:
          if (tick) st_q <= S_IDLE;
      endcase
    end
  end

  // ===================================================
  // pin drivers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      demux_address_port <= DATA_RST;
      seg_address_port <= '0;
      shared_addr_data_port_o <= DATA_RST;
      shared_addr_data_port_oe <= 1'b0;
      addr_latch <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      bhe_n <= 1'b1;
      cs_n <= CS_N_RST;
      exp_sel <= 1'b0;
    end
    else if ((st_q == S_IDLE && accept && go_ext) ||
             (st_q == S_STROBE && tick && cnt_q == CNT_RST && (wr_q || stable) &&
              byte_q && word_q && !second_q))
    begin
      // address phase, also re-entered for the second byte of a pair
      if (st_q == S_IDLE)
      begin
        demux_address_port <= req_addr[15:0];
        seg_address_port <= req_addr[23:16] & SEG_W'((9'd1 << seg_lines) - 9'd1);
        shared_addr_data_port_o <= req_addr[15:0];
        shared_addr_data_port_oe <= fc_d[FC_MUX];
        addr_latch <= fc_d[FC_MUX];
        bhe_n <= fc_d[FC_BYTE] || !(req_word || req_addr[0]);
        exp_sel <= fc_d[FC_EXP];
        cs_n <= CS_N_RST;
        if (!fc_d[FC_EXP] && win_d != 3'd4) cs_n[win_d[1:0]] <= 1'b0;
      end
      else
      begin
        demux_address_port <= next_addr[15:0];
        shared_addr_data_port_o <= next_addr[15:0];
        shared_addr_data_port_oe <= mux_q;
        addr_latch <= mux_q;
      end
      rd_n <= 1'b1;
      wr_n <= 1'b1;
    end
    else if (tick && st_q == S_ADDR)
    begin
      addr_latch <= 1'b0;
      shared_addr_data_port_o <= wlane;
      shared_addr_data_port_oe <= wr_q;
      rd_n <= wr_q;
      wr_n <= !wr_q;
    end
    else if (tick && st_q == S_STROBE && cnt_q == CNT_RST && (wr_q || stable))
    begin
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      shared_addr_data_port_oe <= 1'b0;
      if (finish)
      begin
        cs_n <= CS_N_RST;
        exp_sel <= 1'b0;
      end
    end
    else if (finish)
    begin
      cs_n <= CS_N_RST;
      exp_sel <= 1'b0;
    end
  end

  // ===================================================
  // responses to the internal masters
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      req_ready <= 1'b1;
      resp_done <= 1'b0;
      resp_rdata <= DATA_RST;
      resp_trap <= 1'b0;
      resp_region <= REG_EXTERNAL;
      resp_ordered <= 1'b0;
    end
    else
    begin
      resp_done <= 1'b0;
      if (accept)
      begin
        resp_region <= reg_d;
        resp_ordered <= go_ext && reg_d == REG_EXT_IO;
        resp_trap <= 1'b0;
        resp_rdata <= DATA_RST;
        if (go_ext) req_ready <= 1'b0;
        else
        begin
          // internal regions answer in the next cycle
          resp_done <= 1'b1;
          resp_trap <= (reg_d == REG_TRAP) || (reg_d == REG_EXTERNAL) ||
                       (reg_d == REG_EXT_IO);
          if (reg_d == REG_FLASH_REGS && !req_write) resp_rdata <= FREG_TRAP_CODE;
        end
      end
      else if (tick && st_q == S_STROBE && cnt_q == CNT_RST && !wr_q && stable)
      begin
        if (byte_q && second_q) resp_rdata[15:8] <= s3_q[7:0];
        else if (byte_q || word_q) resp_rdata[7:0] <= s3_q[7:0];
        else resp_rdata[7:0] <= addr_q[0] ? s3_q[15:8] : s3_q[7:0];
        if (!byte_q && word_q) resp_rdata[15:8] <= s3_q[15:8];
      end
      if (finish)
      begin
        resp_done <= 1'b1;
        resp_ordered <= 1'b0;
        req_ready <= 1'b1;
      end
    end
  end
endmodule

// ===== verif/ext_mem_model.sv
// behavioural external memory on the shared data port
`timescale 1ns/1ps
module ext_mem_model
  import ext_bus_pkg::*;
(
  input wire logic clk,
  input wire logic [3:0] cs_n,
  input wire logic exp_sel,
  input wire logic rd_n,
  input wire logic [ext_bus_pkg::DATA_W-1:0] demux_address_port,
  output logic [ext_bus_pkg::DATA_W-1:0] shared_addr_data_port_i
);
  // ====
  // byte at x is x[7:0] ^ 3c, high lane holds the odd byte
  logic [15:0] last_q = 16'h0;
  logic drive;
  logic [15:0] a;
  assign a = demux_address_port;
  assign drive = !rd_n && (!(&cs_n) || exp_sel);
  assign shared_addr_data_port_i = drive ? {{a[7:1], 1'b1}, a[7:0]} ^ 16'h3c3c : ~last_q;
  always @(posedge clk)
    last_q <= shared_addr_data_port_i;
endmodule

// ===== verif/ext_bus_sva.sv
// port checker for the bus window decoder
`timescale 1ns/1ps
module ext_bus_sva
  import ext_bus_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_enable,
  input wire logic [2:0] seg_lines,
  input wire logic req_valid,
  input wire logic [23:0] req_addr,
  input wire logic req_ready,
  input wire logic resp_done,
  input wire logic resp_trap,
  input wire logic resp_ordered,
  input wire logic bus_reference_clock_out,
  input wire logic [7:0] seg_address_port,
  input wire logic shared_addr_data_port_oe,
  input wire logic addr_latch,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] cs_n
);
  // ====
  // properties
  logic take;
  assign take = req_valid && req_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ref_clk;
    $past(nrst) |-> bus_reference_clock_out != $past(bus_reference_clock_out);
  endproperty
  a_ref_clk: assert property (p_ref_clk) else $error("ref clock stuck");
  property p_one_sel; $onehot0(~cs_n); endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects low");
  property p_rd_free; !rd_n |-> !shared_addr_data_port_oe && wr_n; endproperty
  a_rd_free: assert property (p_rd_free) else $error("port driven in read");
  property p_latch; addr_latch |-> shared_addr_data_port_oe && rd_n && wr_n; endproperty
  a_latch: assert property (p_latch) else $error("latch phase wrong");
  property p_program_sram;
    take && req_addr inside {[PROGRAM_SRAM_START:PROGRAM_SRAM_END]} |=> resp_done && req_ready && (&cs_n);
  endproperty
  a_program_sram: assert property (p_program_sram) else $error("program sram not internal");
  property p_trap; take && req_addr inside {[TRAP_START:24'hffefff]} |=> resp_done && resp_trap;
  endproperty
  a_trap: assert property (p_trap) else $error("no access trap");
  property p_io;
    take && bus_enable && req_addr inside {[IO_START:IO_END]} |=> resp_ordered && !req_ready;
  endproperty
  a_io: assert property (p_io) else $error("io access not ordered");
  property p_ext;
    take && bus_enable && req_addr inside {[EXT_HIGH_START:EXT_HIGH_END]}
      |=> !req_ready ##[1:300] resp_done;
  endproperty
  a_ext: assert property (p_ext) else $error("no external cycle");
  property p_seg; !(&cs_n) && $stable(seg_lines) |-> (seg_address_port >> seg_lines) == 8'h0;
  endproperty
  a_seg: assert property (p_seg) else $error("segment lines not masked");
  c_program_sram: cover property (take && req_addr inside {[PROGRAM_SRAM_START:PROGRAM_SRAM_END]});
  c_mux: cover property (addr_latch);
  c_io: cover property ($rose(resp_ordered));
endmodule
bind external_bus_window_decoder ext_bus_sva u_sva (.*);

// ===== verif/external_bus_window_decoder_tb.sv
// self-checking bench for the bus window decoder
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module external_bus_window_decoder_tb;
  import ext_bus_pkg::*;
  typedef struct packed {logic [23:0] a; region_t r; logic t; logic [15:0] d;} row_t;
  logic clk = 1'h0, nrst = 1'h0, bus_enable = 1'h1, req_valid = 1'h0, req_write = 1'h0;
  logic req_word = 1'h1, req_ready, resp_done, resp_trap, resp_ordered, ref_clk, addr_latch;
  logic rd_n, exp_sel, wr_n, bhe_n;
  logic [3:0] def_fc = 4'h0;
  logic [4:0] def_tc = 5'h01;
  logic [15:0] port_o, wd_seen;
  logic [2:0] seg_lines = 3'h7;
  logic [3:0][15:0] rs = {16'h5000, 16'h5008, 16'h4004, 16'h4008};
  logic [3:0][3:0] fc = {4'h9, 4'h1, 4'h1, 4'h7};
  logic [3:0][4:0] tc = {5'h01, 5'h00, 5'h13, 5'h02};
  logic [3:0] cs_n, cs_seen, fl;
  logic [23:0] req_addr = 24'h0;
  logic [15:0] req_wdata = 16'h0, resp_rdata, demux_a, port_i;
  logic [7:0] seg_port, seg_seen;
  region_t resp_region;
  int n_mismatch = 0, checks = 0;
  row_t rows [13] = '{'{24'h008000, REG_SYSTEM, 1'h0, 16'h0},
    '{24'h00fffe, REG_SYSTEM, 1'h0, 16'h0}, '{24'hc00000, REG_FLASH, 1'h0, 16'h0},
    '{24'hc3fffe, REG_FLASH, 1'h0, 16'h0}, '{24'he00000, REG_PROGRAM_SRAM, 1'h0, 16'h0},
    '{24'he017fe, REG_PROGRAM_SRAM, 1'h0, 16'h0}, '{24'he01800, REG_TRAP, 1'h1, 16'h0},
    '{24'h200000, REG_TRAP, 1'h1, 16'h0}, '{24'hbf0000, REG_TRAP, 1'h1, 16'h0},
    '{24'hf80000, REG_TRAP, 1'h1, 16'h0}, '{24'hffeffe, REG_TRAP, 1'h1, 16'h0},
    '{24'hfff000, REG_FLASH_REGS, 1'h0, 16'h00ff}, '{24'hfffffe, REG_FLASH_REGS, 1'h0, 16'h00ff}};
  external_bus_window_decoder DUT (
    .clk(clk), .nrst(nrst), .bus_enable(bus_enable), .seg_lines(seg_lines),
    .window_range_select(rs), .window_function_config(fc), .window_timing_config(tc),
    .default_function_config(def_fc), .default_timing_config(def_tc),
    .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write), .req_word(req_word),
    .req_wdata(req_wdata), .req_ready(req_ready), .resp_done(resp_done),
    .resp_rdata(resp_rdata), .resp_trap(resp_trap), .resp_region(resp_region),
    .resp_ordered(resp_ordered), .bus_reference_clock_out(ref_clk),
    .demux_address_port(demux_a), .seg_address_port(seg_port), .shared_addr_data_port_o(port_o),
    .shared_addr_data_port_oe(), .shared_addr_data_port_i(port_i), .addr_latch(addr_latch),
    .rd_n(rd_n), .wr_n(wr_n), .bhe_n(bhe_n), .cs_n(cs_n), .exp_sel(exp_sel)
  );
  ext_mem_model MEM (
    .clk(clk), .cs_n(cs_n), .exp_sel(exp_sel), .rd_n(rd_n),
    .demux_address_port(demux_a), .shared_addr_data_port_i(port_i)
  );
  // ====
  // tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic access(input logic [23:0] a, input logic w);
    int k;
    @(negedge clk);
    while (req_ready !== 1'h1) @(negedge clk);
    req_addr = a;
    req_write = w;
    req_wdata = a[15:0];
    req_valid = 1'h1;
    cs_seen = 4'hf;
    fl = 4'h0;
    wd_seen = 16'h0;
    @(negedge clk);
    req_valid = 1'h0;
    for (k = 0; k < 300 && resp_done !== 1'h1; k++)
    begin
      @(negedge clk);
      cs_seen &= cs_n;
      fl |= {addr_latch, exp_sel, resp_ordered, ~req_ready};
      if (!(&cs_n)) seg_seen = seg_port;
      if (!wr_n) wd_seen = port_o;
    end
    `CHK("done", 1'h1, resp_done)
  endtask
  task automatic ext(input logic [23:0] a, input logic w, input logic [3:0] c, f,
    input logic [15:0] d);
    access(a, w);
    `CHK("selects", c, cs_seen)
    `CHK("flags", f, fl)
    `CHK("rdata", d, resp_rdata)
    $display("access %h done", a);
  endtask
  // ====
  // stimulus
  initial forever #10 clk = ~clk;
  initial
  begin
    #400000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(negedge clk);
    `CHK("reset selects", 4'hf, cs_n)
    nrst = 1'h1;
    foreach (rows[i])
    begin
      access(rows[i].a, 1'h0);
      `CHK("region", rows[i].r, resp_region)
      `CHK("trap", rows[i].t, resp_trap)
      `CHK("rdata", rows[i].d, resp_rdata)
      `CHK("internal", 8'hf0, {cs_seen, fl})
    end
    $display("map table done");
    ext(24'h010000, 1'h0, 4'he, 4'h1, 16'h3d3c);
    `CHK("segment", 8'h01, seg_seen)
    ext(24'h400002, 1'h0, 4'hb, 4'h1, 16'h3f3e);
    ext(24'h410004, 1'h0, 4'hd, 4'h9, 16'h3938);
    `CHK("byte enable", 1'h1, bhe_n)
    ext(24'h5a0000, 1'h0, 4'h7, 4'h1, 16'h3d3c);
    ext(24'h500000, 1'h0, 4'hf, 4'h5, 16'h3d3c);
    req_word = 1'h0;
    ext(24'h5a0003, 1'h0, 4'h7, 4'h1, 16'h003f);
    `CHK("byte enable", 1'h0, bhe_n)
    req_word = 1'h1;
    ext(24'h21a5c6, 1'h1, 4'he, 4'h3, 16'h0000);
    `CHK("write data", 16'ha5c6, wd_seen)
    seg_lines = 3'h3;
    def_fc = 4'h6;
    def_tc = 5'h12;
    ext(24'h7a0000, 1'h0, 4'he, 4'h9, 16'h3d3c);
    `CHK("segment", 8'h02, seg_seen)
    bus_enable = 1'h0;
    ext(24'h010000, 1'h0, 4'hf, 4'h0, 16'h0000);
    `CHK("single chip trap", 1'h1, resp_trap)
    bus_enable = 1'h1;
    req_addr = 24'h410004;
    req_valid = 1'h1;
    repeat (6) @(negedge clk);
    req_valid = 1'h0;
    nrst = 1'h0;
    @(negedge clk);
    `CHK("reset selects", 4'hf, cs_n)
    `CHK("reset strobe", 1'h1, rd_n)
    `CHK("reset ready", 1'h1, req_ready)
    nrst = 1'h1;
    $display("mid-run reset done");
    ext(24'h400002, 1'h0, 4'hb, 4'h1, 16'h3f3e);
    complete_run();
  end
endmodule
